// ==== mdsca_pkg.sv ====
// Package with offsets, field positions, reset values and counts for sync align.
package mdsca_pkg;

    // Register byte offsets on the APB bus.
    localparam logic [7:0] OFS_FUNC_ONE = 8'h00;
    localparam logic [7:0] OFS_FUNC_TWO = 8'h04;
    localparam logic [7:0] OFS_STATUS   = 8'h08;

    // Field positions in function_reg_one.
    localparam int FR1_SW_SYNC = 0;
    localparam int FR1_HW_SYNC = 1;

    // Field positions in function_reg_two.
    localparam int FR2_OFS_LO   = 0;
    localparam int FR2_MASK     = 4;
    localparam int FR2_FLAG     = 5;
    localparam int FR2_MASTER   = 6;
    localparam int FR2_AUTO_EN  = 7;

    // Field positions in the status register.
    localparam int ST_PHASE_LO  = 0;
    localparam int ST_SYNC_CLK  = 2;
    localparam int ST_UPD_PEND  = 3;

    // Values after reset.
    localparam logic [1:0] FR1_RESET    = 2'h0;
    localparam logic [7:0] FR2_RESET    = 8'h00;

    // Counts of system clock cycles, and phase values of the clock generator.
    localparam int          SYNC_DIV     = 4;
    localparam int          SYNC_STAGES  = 2;
    localparam int          DELAY_TAPS   = 3;
    localparam logic [1:0]  EXP_PHASE    = 2'h2;
    localparam logic [1:0]  PHASE_RISE   = 2'h1;

endpackage

// ==== mdsca_sync2.sv ====
// Two flip-flop synchroniser with a rising edge detector behind it.
`timescale 1ns/10ps
module mdsca_sync2 (
    input  wire logic clock_i,
    input  wire logic rstn_i,
    input  wire logic d_i,
    output logic      q_o,
    output logic      rise_o
);
    typedef struct packed {
        logic s1;
        logic s2;
        logic prev;
    } mdsca_sync_t;

    mdsca_sync_t cur_ff;
    mdsca_sync_t nxt_cur;

    always_comb begin
        nxt_cur      = cur_ff;
        nxt_cur.s1   = d_i;
        nxt_cur.s2   = cur_ff.s1;
        nxt_cur.prev = cur_ff.s2;
    end

    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            // Reset to the idle high level of a pulled-up pin.
            // A low-idle input then shows no edge, and a high one no false edge.
            cur_ff <= '1;
        end else begin
            cur_ff <= nxt_cur;
        end
    end

    assign q_o    = cur_ff.s2;
    assign rise_o = cur_ff.s2 & ~cur_ff.prev;
endmodule

// ==== mdsca_clkgen.sv ====
// Divide-by-four sync clock generator whose state machine can be stalled.
`timescale 1ns/10ps
module mdsca_clkgen (
    input  wire logic       clock_i,
    input  wire logic       rstn_i,
    input  wire logic       stall_i,
    output logic [1:0]      phase_o,
    output logic            sync_clk_o,
    output logic            tick_o
);
    typedef struct packed {
        logic [1:0] cnt;
        logic       clk;
    } mdsca_gen_t;

    mdsca_gen_t cur_ff;
    mdsca_gen_t nxt_cur;

    always_comb begin
        nxt_cur = cur_ff;
        if (!stall_i) begin
            nxt_cur.cnt = cur_ff.cnt + 2'h1;
        end
        nxt_cur.clk = nxt_cur.cnt[1];
    end

    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cur_ff <= '0;
        end else begin
            cur_ff <= nxt_cur;
        end
    end

    assign phase_o    = cur_ff.cnt;
    assign sync_clk_o = cur_ff.clk;
    // High in the cycle before the sync clock rises.
    assign tick_o     = ~stall_i && (cur_ff.cnt == mdsca_pkg::PHASE_RISE);
endmodule

// ==== mdsca_top.sv ====
// Multi-device sync clock alignment with its APB register file.
//
// Chosen here: the APB slave port and the placing of the registers.
`timescale 1ns/10ps

// What this block does
// RQ1: Three alignment methods force known clock state.
// RQ2: Controller sends update strobe to all devices together.
// RQ3: Auto sync runs only when enable bit set.
// RQ4: Master bit one makes master, zero slave.
// RQ5: Master emits one-cycle pulse every four cycles.
// RQ6: Slave compares phase, stalls one cycle on mismatch.
// RQ7: Slave aligns within three sync clock periods.
// RQ8: Offset code compensates zero to three cycles.
// RQ9: Integrator measures delay and programs offset code.
// RQ10: Slave sets flag on loss; read clears it.
// RQ11: Alignment runs regardless of status flag.
// RQ12: Mask bit holds status flag low.
// RQ13: Software sync bit enables software mode.
// RQ14: Update clearing software bit stalls one cycle.
// RQ15: Manual modes leave sync output unused; sync_out_o still pulses when the auto and master bits are set.
// RQ16: Hardware sync bit enables hardware mode.
// RQ17: Each sync input rising edge stalls once.
// RQ18: Controller repeats stalls until all in phase.
// RQ19: Role and sync bits programmable by software.
// RQ20: Sync clock is system clock divided four.
// RQ21: Update strobe held beyond one sync period.
// RQ22: Sampled pulse delayed by offset before compare.
module mdsca_top (
    input  wire logic        clock_i,
    input  wire logic        rstn_i,
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [7:0]  paddr_i,
    input  wire logic [31:0] pwdata_i,
    output logic [31:0]      prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    input  wire logic        sync_in_i,
    input  wire logic        io_update_i,
    output logic             sync_out_o,
    output logic             sync_clk_o
);
    typedef struct packed {
        logic [1:0]  fr1_buf;
        logic [7:0]  fr2_buf;
        logic [1:0]  fr1_act;
        logic [7:0]  fr2_act;
        logic        flag;
        logic        upd_pend;
        logic        stall;
        logic        sync_out;
        logic [2:0]  dly;
        logic [31:0] rdata;
        logic        err;
    } mdsca_state_t;

    mdsca_state_t cur_ff;
    mdsca_state_t nxt_cur;

    logic [1:0] phase;
    logic       tick;
    logic       sin_q;
    logic       sin_rise;
    logic       upd_q;
    logic       upd_rise;
    logic       setup_ph;
    logic       access_ph;
    logic       auto_on;
    logic       is_master;
    logic       auto_slave;
    logic       hw_mode;
    logic       sw_mode;
    logic       cmp_pulse;
    logic       mismatch;
    logic       hw_stall;
    logic       sw_stall;
    logic       rd_clear;

    // Picks the delay tap that makes the total pulse delay constant.
    function automatic logic tap_pick(input logic [1:0] code,
                                      input logic       now,
                                      input logic [2:0] line);
        logic res;
        res = now;
        case (code)
            2'h0:    res = line[2];
            2'h1:    res = line[1];
            2'h2:    res = line[0];
            2'h3:    res = now;
            default: res = now;
        endcase
        return res;
    endfunction

    function automatic logic addr_hit(input logic [7:0] a,
                                      input logic [7:0] ofs);
        return a == ofs;
    endfunction

    mdsca_sync2 u_sync_in (
        .clock_i (clock_i),
        .rstn_i  (rstn_i),
        .d_i     (sync_in_i),
        .q_o     (sin_q),
        .rise_o  (sin_rise)
    );

    mdsca_sync2 u_sync_upd (
        .clock_i (clock_i),
        .rstn_i  (rstn_i),
        .d_i     (io_update_i),
        .q_o     (upd_q),
        .rise_o  (upd_rise)
    );

    mdsca_clkgen u_clkgen (
        .clock_i    (clock_i),
        .rstn_i     (rstn_i),
        .stall_i    (cur_ff.stall),
        .phase_o    (phase),
        .sync_clk_o (sync_clk_o),
        .tick_o     (tick)
    );

    assign setup_ph  = psel_i & ~penable_i;
    assign access_ph = psel_i & penable_i;

    assign auto_on    = cur_ff.fr2_act[mdsca_pkg::FR2_AUTO_EN];  // [RQ3]
    assign is_master  = cur_ff.fr2_act[mdsca_pkg::FR2_MASTER];   // [RQ4]
    assign hw_mode    = cur_ff.fr1_act[mdsca_pkg::FR1_HW_SYNC];  // [RQ16]
    assign sw_mode    = cur_ff.fr1_act[mdsca_pkg::FR1_SW_SYNC];  // [RQ13]
    assign auto_slave = auto_on & ~is_master & ~hw_mode & ~sw_mode;

    // Synchroniser and delay line add up to five cycles less the offset code.
    assign cmp_pulse = tap_pick(cur_ff.fr2_act[1:0], sin_rise,
                                cur_ff.dly);                     // [RQ22] [RQ8]
    assign mismatch  = auto_slave & cmp_pulse &
                       (phase != mdsca_pkg::EXP_PHASE);          // [RQ6]
    assign hw_stall  = hw_mode & sin_rise;                       // [RQ17]
    // A sync clock edge with an update pending loads the active copies.
    assign sw_stall  = tick & cur_ff.upd_pend & sw_mode &
                       ~cur_ff.fr1_buf[mdsca_pkg::FR1_SW_SYNC];  // [RQ14]
    assign rd_clear  = access_ph & ~pwrite_i &
                       addr_hit(paddr_i, mdsca_pkg::OFS_FUNC_TWO);

    always_comb begin
        nxt_cur = cur_ff;
        nxt_cur.dly   = {cur_ff.dly[1:0], sin_rise};
        // All methods share this one-cycle stall of the clock generator.
        nxt_cur.stall = mismatch | hw_stall | sw_stall;          // [RQ1] [RQ7]
        // Pulse leaves in the cycle after phase zero, one cycle wide.
        nxt_cur.sync_out = auto_on & is_master &
                           (phase == 2'h0) & ~cur_ff.stall;      // [RQ5] [RQ15]
        if (upd_rise) begin
            nxt_cur.upd_pend = 1'b1;
        end
        if (tick && cur_ff.upd_pend) begin
            nxt_cur.upd_pend = upd_rise;
            nxt_cur.fr1_act  = cur_ff.fr1_buf;
            nxt_cur.fr2_act  = cur_ff.fr2_buf;
        end
        if (access_ph && pwrite_i) begin                          // [RQ19]
            if (addr_hit(paddr_i, mdsca_pkg::OFS_FUNC_ONE)) begin
                nxt_cur.fr1_buf = pwdata_i[1:0];
            end
            if (addr_hit(paddr_i, mdsca_pkg::OFS_FUNC_TWO)) begin
                nxt_cur.fr2_buf = pwdata_i[7:0];
                nxt_cur.fr2_buf[mdsca_pkg::FR2_FLAG] = 1'b0;
            end
        end
        // A new loss of sync wins over the clear done by a read.
        if (rd_clear) begin
            nxt_cur.flag = 1'b0;                                  // [RQ10]
        end
        if (mismatch) begin
            nxt_cur.flag = 1'b1;                                  // [RQ10] [RQ11]
        end
        if (cur_ff.fr2_act[mdsca_pkg::FR2_MASK]) begin
            nxt_cur.flag = 1'b0;                                  // [RQ12]
        end
        if (setup_ph) begin
            nxt_cur.err   = 1'b0;
            nxt_cur.rdata = 32'h0000_0000;
            case (paddr_i)
                mdsca_pkg::OFS_FUNC_ONE: begin
                    nxt_cur.rdata[1:0] = cur_ff.fr1_buf;
                end
                mdsca_pkg::OFS_FUNC_TWO: begin
                    nxt_cur.rdata[7:0] = cur_ff.fr2_buf;
                    nxt_cur.rdata[mdsca_pkg::FR2_FLAG] = cur_ff.flag;
                end
                mdsca_pkg::OFS_STATUS: begin
                    nxt_cur.rdata[1:0] = phase;
                    nxt_cur.rdata[mdsca_pkg::ST_SYNC_CLK] = sync_clk_o;
                    nxt_cur.rdata[mdsca_pkg::ST_UPD_PEND] =
                        cur_ff.upd_pend;
                end
                default: begin
                    nxt_cur.err = 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cur_ff         <= '0;
            cur_ff.fr1_buf <= mdsca_pkg::FR1_RESET;
            cur_ff.fr2_buf <= mdsca_pkg::FR2_RESET;
            cur_ff.fr1_act <= mdsca_pkg::FR1_RESET;
            cur_ff.fr2_act <= mdsca_pkg::FR2_RESET;
        end else begin
            cur_ff <= nxt_cur;
        end
    end

    assign prdata_o   = cur_ff.rdata;
    assign pslverr_o  = cur_ff.err & access_ph;
    assign pready_o   = 1'b1;
    assign sync_out_o = cur_ff.sync_out;

    default clocking dc @(posedge clock_i);
    endclocking
    default disable iff (!rstn_i);

    // Helper: count cycles since the last stall.
    logic [3:0] gap_cnt_ff;
    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            gap_cnt_ff <= 4'h0;
        end else if (cur_ff.stall) begin
            gap_cnt_ff <= 4'h0;
        end else if (gap_cnt_ff != 4'hf) begin
            gap_cnt_ff <= gap_cnt_ff + 4'h1;
        end
    end

    a_master_pulse_width: assert property ( // [RQ5]
        sync_out_o |=> !sync_out_o ##1 !sync_out_o ##1 !sync_out_o)
        else $error("Master sync pulse wider or faster than allowed.");
    a_master_pulse_rate: assert property ( // [RQ5]
        (sync_out_o && auto_on && is_master && !cur_ff.stall) ##1
        (auto_on && is_master && !cur_ff.stall) [*3] |=> sync_out_o)
        else $error("Master sync pulse missing after four cycles.");
    a_no_out_manual: assert property ( // [RQ15]
        !(auto_on && is_master) |=> !sync_out_o)
        else $error("Sync output driven outside master auto mode.");
    a_mismatch_stall: assert property ( // [RQ6]
        mismatch |=> cur_ff.stall ##1 !cur_ff.stall)
        else $error("Slave mismatch did not stall exactly one cycle.");
    a_stall_holds_phase: assert property ( // [RQ20]
        cur_ff.stall |=> phase == $past(phase))
        else $error("Clock generator moved during a stall.");
    a_div_four: assert property ( // [RQ20]
        !cur_ff.stall |=> phase == $past(phase) + 2'h1)
        else $error("Clock generator did not advance.");
    a_hw_edge_stall: assert property ( // [RQ17]
        (hw_mode && sin_rise) |=> cur_ff.stall)
        else $error("Hardware sync edge did not stall.");
    a_mask_flag_low: assert property ( // [RQ12]
        cur_ff.fr2_act[mdsca_pkg::FR2_MASK] |=> !cur_ff.flag)
        else $error("Masked status flag went high.");
    a_flag_sets: assert property ( // [RQ10]
        (mismatch && !cur_ff.fr2_act[mdsca_pkg::FR2_MASK]) |=> cur_ff.flag)
        else $error("Loss of sync did not set the flag.");
    a_read_clears: assert property ( // [RQ10]
        (rd_clear && !mismatch) |=> !cur_ff.flag)
        else $error("Reading the flag did not clear it.");
    a_no_auto_off: assert property ( // [RQ3]
        !auto_on && !hw_mode && !sw_mode |=> !cur_ff.stall)
        else $error("Stall while no sync method is active.");

    c_auto_stall: cover property (auto_slave && mismatch);
    c_hw_stall: cover property (hw_stall ##1 cur_ff.stall);
    c_sw_stall: cover property (sw_stall ##1 cur_ff.stall);
    c_flag_read: cover property (cur_ff.flag ##[1:20] rd_clear);
    c_realign: cover property (auto_slave && cur_ff.stall &&
                               gap_cnt_ff == 4'h3);
endmodule

// ==== mdsca_peer.sv ====
// Behavioural peer device: sync master and driver of the sync line.
`timescale 1ns/10ps
module mdsca_peer (
    input  wire logic       clock_i,
    input  wire logic       rstn_i,
    input  wire logic       en_i,
    input  wire logic [1:0] delay_i,
    input  wire logic       level_i,
    output logic            pulse_o,
    output logic            sclk_o,
    output logic            sync_o
);
    logic [1:0] phase_ff;
    logic [2:0] line_ff;

    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            phase_ff <= 2'h0;
            pulse_o  <= 1'b0;
            line_ff  <= 3'h0;
        end else begin
            phase_ff <= phase_ff + 2'h1;
            pulse_o  <= (phase_ff == 2'h0);
            line_ff  <= {line_ff[1:0], pulse_o};
        end
    end

    assign sclk_o = phase_ff[1];

    // When not sending, the line rests at level_i, high like a pull-up.
    always_comb begin
        if (!en_i) begin
            sync_o = level_i;
        end else if (delay_i == 2'h0) begin
            sync_o = pulse_o;
        end else begin
            sync_o = line_ff[delay_i - 2'h1];
        end
    end
endmodule

// ==== multi_device_sync_clock_align_tb.sv ====
// Self-checking bench for the sync alignment block and its registers.
`timescale 1ns/10ps
module multi_device_sync_clock_align_tb;
    logic        clock_i   = 1'b0;
    logic        rstn_i    = 1'b0;
    logic        psel_i    = 1'b0;
    logic        penable_i = 1'b0;
    logic        pwrite_i  = 1'b0;
    logic [7:0]  paddr_i   = 8'h00;
    logic [31:0] pwdata_i  = 32'h0;
    logic        io_update_i = 1'b0;
    logic        en        = 1'b0;
    logic [1:0]  delay     = 2'h0;
    logic        level     = 1'b1;
    logic [31:0] prdata_o;
    logic        pready_o;
    logic        pslverr_o;
    logic        sync_in_i;
    logic        sync_out_o;
    logic        sync_clk_o;
    logic        pulse;
    logic        sclk;
    logic [31:0] rd;
    logic        err;
    int          miscompares = 0;
    int          comparisons = 0;

    always #2.5 clock_i = ~clock_i;

    mdsca_top u_mdsca_top (
        .clock_i(clock_i), .rstn_i(rstn_i), .psel_i(psel_i),
        .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
        .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
        .pslverr_o(pslverr_o), .sync_in_i(sync_in_i),
        .io_update_i(io_update_i), .sync_out_o(sync_out_o),
        .sync_clk_o(sync_clk_o));

    mdsca_peer u_mdsca_peer (
        .clock_i(clock_i), .rstn_i(rstn_i), .en_i(en), .delay_i(delay),
        .level_i(level), .pulse_o(pulse), .sclk_o(sclk), .sync_o(sync_in_i));

    task automatic check32(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] wd);
        @(posedge clock_i);
        psel_i    <= 1'b1;
        penable_i <= 1'b0;
        pwrite_i  <= wr;
        paddr_i   <= a;
        pwdata_i  <= wd;
        @(posedge clock_i);
        penable_i <= 1'b1;
        do @(posedge clock_i); while (pready_o !== 1'b1);
        rd = prdata_o;
        err = pslverr_o;
        psel_i    <= 1'b0;
        penable_i <= 1'b0;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        check32(rd, exp);
    endtask

    // The strobe is held well past one sync clock period, then settles.
    task automatic update();
        @(posedge clock_i);
        io_update_i <= 1'b1;
        repeat (8) @(posedge clock_i);
        io_update_i <= 1'b0;
        repeat (12) @(posedge clock_i);
    endtask

    // Counts cycles where the local sync clock differs from the peer's.
    task automatic diffs(input int exp);
        int n;
        n = 0;
        repeat (16) begin
            @(negedge clock_i);
            if (sync_clk_o !== sclk) n++;
        end
        check32(n, exp);
    endtask

    task automatic tally_and_finish();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge clock_i);
        miscompares++;
        tally_and_finish();
    end

    initial begin
        repeat (8) @(posedge clock_i);
        rstn_i <= 1'b1;
        rd_chk(mdsca_pkg::OFS_FUNC_ONE, 32'h0);
        rd_chk(mdsca_pkg::OFS_FUNC_TWO, 32'h0);
        rd_chk(8'h0c, 32'h0);
        check32({31'h0, err}, 32'h1);
        // Master role: pulse train and divided clock match the peer.
        apb(1'b1, mdsca_pkg::OFS_FUNC_TWO, 32'hc0);
        update();
        rd_chk(mdsca_pkg::OFS_FUNC_TWO, 32'hc0);
        repeat (16) begin
            @(negedge clock_i);
            check32({31'h0, sync_out_o}, {31'h0, pulse});
        end
        diffs(0);
        // Software mode: clearing the bit shifts the phase by one cycle.
        apb(1'b1, mdsca_pkg::OFS_FUNC_TWO, 32'h00);
        apb(1'b1, mdsca_pkg::OFS_FUNC_ONE, 32'h1);
        update();
        check32({31'h0, sync_out_o}, 32'h0);
        apb(1'b1, mdsca_pkg::OFS_FUNC_ONE, 32'h0);
        update();
        diffs(8);
        // Hardware mode: one rising edge on the sync line, one more shift.
        apb(1'b1, mdsca_pkg::OFS_FUNC_ONE, 32'h2);
        update();
        level <= 1'b0;
        repeat (4) @(posedge clock_i);
        level <= 1'b1;
        repeat (8) @(posedge clock_i);
        diffs(16);
        apb(1'b1, mdsca_pkg::OFS_FUNC_ONE, 32'h0);
        update();
        diffs(16);
        // Automatic slave, line delay below one cycle, flag then cleared.
        en <= 1'b1;
        apb(1'b1, mdsca_pkg::OFS_FUNC_TWO, 32'h80);
        update();
        repeat (20) @(posedge clock_i);
        diffs(0);
        rd_chk(mdsca_pkg::OFS_FUNC_TWO, 32'ha0);
        rd_chk(mdsca_pkg::OFS_FUNC_TWO, 32'h80);
        // Masked slave with two cycles of line delay and offset code 10.
        delay <= 2'h2;
        apb(1'b1, mdsca_pkg::OFS_FUNC_TWO, 32'h92);
        apb(1'b1, mdsca_pkg::OFS_FUNC_ONE, 32'h1);
        update();
        apb(1'b1, mdsca_pkg::OFS_FUNC_ONE, 32'h0);
        update();
        repeat (20) @(posedge clock_i);
        diffs(0);
        rd_chk(mdsca_pkg::OFS_FUNC_TWO, 32'h92);
        tally_and_finish();
    end
endmodule
